// *** ram_io_timer_peripheral_test.sv ***
/*
  Bench for rit_periph: bus tasks, then timer, edge, port and RAM sequences.
  Assumes rit_pkg, rit_pin_model and rit_monitor are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module ram_io_timer_peripheral_test;
  import rit_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tflag;
  logic        eflag;
  logic [12:0] addr = 13'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  ext_a = 8'h00;
  logic [7:0]  ext_en = 8'h00;
  logic [7:0]  rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, v, w;
  int          fails = 0;
  int          samples_checked = 0;
  int          divs [4] = '{1, 8, 64, 1024};
  always #25 clk = ~clk;
  rit_periph dut (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .RDATA_OUT(rdata), .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE_OUT(pa_oe), .PORT_B_IN(pb_in),
    .PORT_B_OUT(pb_out), .PORT_B_OE_OUT(pb_oe), .TIMER_FLAG_OUT(tflag), .EDGE_FLAG_OUT(eflag));
  rit_pin_model pins_a (.oe_in(pa_oe), .drv_in(pa_out), .ext_en_in(ext_en), .ext_in(ext_a), .pin_out(pa_in));
  rit_pin_model pins_b (.oe_in(pb_oe), .drv_in(pb_out), .ext_en_in(8'h00), .ext_in(8'h00), .pin_out(pb_in));
  // ---------------------
  // Bus tasks
  // ---------------------
  task automatic final_report;
    $display("samples_checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr8(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [12:0] a, input logic [7:0] exp);
    rd8(a, v);
    chk(v, exp);
  endtask
  task automatic flag_seen;
    repeat (3) @(posedge clk);
    rc(13'h0291, 8'h40);
  endtask
  initial
  begin
    #400000;
    fails++;
    final_report;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(pa_oe, 8'h00);
    chk(pb_oe, 8'h00);
    rd8(13'h0291, v);
    for (int c = 0; c < 4; c++)
    begin
      wr8(13'h0294 + 13'(c), 8'h40);
      rd8(13'h0294, v);
      repeat (2 * divs[c] - 2) @(posedge clk);
      rd8(13'h0294, w);
      chk(v - w, 8'h02);
    end
    wr8(13'h0295, 8'h01);
    for (int k = 0; k < 60 && tflag !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, tflag}, 8'h01);
    rc(13'h0291, 8'h80);
    rc(13'h0294, 8'hFC);
    chk({7'h00, tflag}, 8'h00);
    wr8(13'h0294, 8'h01);
    rc(13'h0294, 8'h00);
    chk({7'h00, tflag}, 8'h01);
    // Parking the timer at the slowest rate keeps its flag out of the later reads.
    wr8(13'h0297, 8'hFF);
    ext_en <= 8'h80;
    flag_seen;
    rc(13'h0291, 8'h00);
    wr8(13'h0291, 8'h00);
    ext_a <= 8'h80;
    flag_seen;
    wr8(13'h0290, 8'hFF);
    wr8(13'h0280, 8'h80);
    wr8(13'h0281, 8'h80);
    ext_en <= 8'h00;
    wr8(13'h0280, 8'h00);
    flag_seen;
    ext_a <= 8'h3C;
    ext_en <= 8'hFF;
    wr8(13'h0281, 8'h0F);
    wr8(13'h0280, 8'hA5);
    rc(13'h0280, 8'h35);
    wr8(13'h0281, 8'hFF);
    rc(13'h0280, 8'hA5);
    wr8(13'h0283, 8'hFF);
    wr8(13'h0282, 8'hFF);
    rc(13'h0282, 8'hCB);
    rc(13'h0283, 8'hCB);
    wr8(13'h0080, 8'h11);
    wr8(13'h00FF, 8'hEE);
    wr8(13'h1080, 8'h77);
    rc(13'h0080, 8'h11);
    rc(13'h00FF, 8'hEE);
    rc(13'h1080, 8'h00);
    final_report;
  end
endmodule
bind rit_periph rit_monitor mon (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .PORT_A_IN(PORT_A_IN), .PORT_A_OUT(PORT_A_OUT),
  .PORT_A_OE_OUT(PORT_A_OE_OUT), .PORT_B_OUT(PORT_B_OUT), .PORT_B_OE_OUT(PORT_B_OE_OUT),
  .TIMER_FLAG_OUT(TIMER_FLAG_OUT), .EDGE_FLAG_OUT(EDGE_FLAG_OUT));
`default_nettype wire

// *** rit_monitor.sv ***
/*
  Checker for rit_periph: bus, port, edge flag and timer flag relations.
  Assumes it is bound to rit_periph and that there is one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rit_monitor (
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic [12:0] ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  input wire logic [7:0]  PORT_A_IN,
  input wire logic [7:0]  PORT_A_OUT,
  input wire logic [7:0]  PORT_A_OE_OUT,
  input wire logic [7:0]  PORT_B_OUT,
  input wire logic [7:0]  PORT_B_OE_OUT,
  input wire logic        TIMER_FLAG_OUT,
  input wire logic        EDGE_FLAG_OUT
);
  // ---------------------
  // Edge tracking
  // ---------------------
  logic pol_r;
  logic prev_r;
  logic edg;
  // Only the exact polarity addresses are tracked, so aliases must stay unused.
  always_ff @(posedge CLK_IN)
  begin
    prev_r <= PORT_A_IN[7];
    if (!RST_B_IN)
      pol_r <= 1'b0;
    else if (WR_IN && ADDR_IN == 13'h0290)
      pol_r <= 1'b0;
    else if (WR_IN && ADDR_IN == 13'h0291)
      pol_r <= 1'b1;
  end
  assign edg = pol_r ? (!prev_r && PORT_A_IN[7]) : (prev_r && !PORT_A_IN[7]);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  dir_reset_a: assert property ($rose(RST_B_IN) |-> PORT_A_OE_OUT == 8'h00 && PORT_B_OE_OUT == 8'h00)
    else $error("direction not cleared by reset");
  dir_write_a: assert property (WR_IN && ADDR_IN == 13'h0281 |=> PORT_A_OE_OUT == $past(WDATA_IN))
    else $error("port A direction not loaded");
  latch_write_a: assert property (WR_IN && ADDR_IN == 13'h0280
    |=> PORT_A_OUT == $past(WDATA_IN) && $stable(PORT_A_OE_OUT))
    else $error("port A latch not loaded");
  port_b_a: assert property (WR_IN && ADDR_IN == 13'h0282 |=> PORT_B_OUT == ($past(WDATA_IN) & 8'hCB))
    else $error("port B latch wrong");
  pin_read_a: assert property (RD_IN && ADDR_IN == 13'h0280 |=> RDATA_OUT == $past(PORT_A_IN))
    else $error("port A read is not the pins");
  edge_set_a: assert property (edg |-> ##[0:2] EDGE_FLAG_OUT)
    else $error("edge flag not set");
  flag_read_a: assert property (RD_IN && ADDR_IN == 13'h0291
    |=> RDATA_OUT == {$past(TIMER_FLAG_OUT), $past(EDGE_FLAG_OUT), 6'h00})
    else $error("flag register read wrong");
  timer_clear_a: assert property (TIMER_FLAG_OUT && (RD_IN || WR_IN) && ADDR_IN[12:2] == 11'h0A5
    |=> !TIMER_FLAG_OUT)
    else $error("timer flag not cleared");
endmodule
`default_nettype wire

// *** rit_periph.sv ***
/*
  Peripheral section: 128-byte RAM, two bidirectional ports, edge
  detector on port A line 7 and an eight-bit interval timer.
  Assumes a single clock and a processor bus with one-cycle strobes;
  read data stands in the cycle after the read strobe.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module rit_periph
  import rit_pkg::*;
(
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_B_IN,
  input  wire logic [rit_pkg::ADDR_W-1:0] ADDR_IN,
  input  wire logic [rit_pkg::DATA_W-1:0] WDATA_IN,
  input  wire logic                   WR_IN,
  input  wire logic                   RD_IN,
  output logic      [rit_pkg::DATA_W-1:0] RDATA_OUT,
  input  wire logic [7:0]             PORT_A_IN,
  output logic      [7:0]             PORT_A_OUT,
  output logic      [7:0]             PORT_A_OE_OUT,
  input  wire logic [7:0]             PORT_B_IN,
  output logic      [7:0]             PORT_B_OUT,
  output logic      [7:0]             PORT_B_OE_OUT,
  output logic                        TIMER_FLAG_OUT,
  output logic                        EDGE_FLAG_OUT
);
  import rit_pkg::*;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  rit_bus_s bus;
  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  function automatic logic periph_sel(input logic [ADDR_W-1:0] a);
    periph_sel = a[A_SEL_HI] && !a[A_SEL_LO];
  endfunction

  logic sel;
  logic ram_sel;
  logic port_sel;
  logic tmr_sel;
  logic edg_wsel;
  logic flg_rsel;

  always_comb
  begin
    sel      = periph_sel(bus.addr);
    ram_sel  = sel && !bus.addr[A_RAM_SEL];
    port_sel = sel && bus.addr[A_RAM_SEL] && !bus.addr[A_TMR_SEL] && !bus.addr[A_EDG_SEL];
    tmr_sel  = sel && bus.addr[A_RAM_SEL] && bus.addr[A_TMR_SEL] && bus.addr[A_EDG_SEL];
    edg_wsel = sel && bus.addr[A_RAM_SEL] && bus.addr[A_TMR_SEL] && !bus.addr[A_EDG_SEL];
    flg_rsel = sel && bus.addr[A_RAM_SEL] && bus.addr[A_TMR_SEL] && bus.addr[0] && !bus.addr[A_EDG_SEL];
  end

  // ------------------------------------------------------------------
  // Scratch RAM
  // ------------------------------------------------------------------
  logic [7:0] ram_r [0:(1<<RAM_AW)-1];

  always_ff @(posedge CLK_IN)
  begin
    if (bus.wr && ram_sel)
      ram_r[bus.addr[RAM_AW-1:0]] <= bus.wdata;
  end

  // ------------------------------------------------------------------
  // Ports
  // ------------------------------------------------------------------
  logic [7:0] a_dir_r;
  logic [7:0] a_lat_r;
  logic [7:0] b_dir_r;
  logic [7:0] b_lat_r;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      a_dir_r <= DIR_RST;
      b_dir_r <= DIR_RST;
      a_lat_r <= LATCH_RST;
      b_lat_r <= LATCH_RST;
    end
    else if (bus.wr && port_sel)
    begin
      // Latch writes are kept whatever the direction.
      case (bus.addr[1:0])
        PORT_A_DATA: a_lat_r <= bus.wdata;
        PORT_A_DIR:  a_dir_r <= bus.wdata;
        PORT_B_DATA: b_lat_r <= bus.wdata & PORT_B_MASK;
        PORT_B_DIR:  b_dir_r <= bus.wdata & PORT_B_MASK;
        default:     a_dir_r <= a_dir_r;
      endcase
    end
  end

  assign PORT_A_OE_OUT = a_dir_r;
  assign PORT_A_OUT    = a_lat_r;
  assign PORT_B_OE_OUT = b_dir_r;
  assign PORT_B_OUT    = b_lat_r;

  // ------------------------------------------------------------------
  // Edge detector on port A line 7
  // ------------------------------------------------------------------
  logic edg_pol_r;   // 1 = rising, 0 = falling.
  logic edg_prev_r;
  logic edg_flag_r;
  logic edg_hit;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      edg_pol_r <= POL_FALL;
    else if (bus.wr && edg_wsel)
      edg_pol_r <= bus.addr[0];
  end

  always_ff @(posedge CLK_IN)
  begin
    edg_prev_r <= PORT_A_IN[7];
  end

  // The pin is sampled regardless of its direction, so outputs also trigger.
  assign edg_hit = edg_pol_r ? (PORT_A_IN[7] && !edg_prev_r)
                             : (!PORT_A_IN[7] && edg_prev_r);

  always_ff @(posedge CLK_IN)
  begin
    // Edge detection still runs during reset so a falling edge may flag.
    if (edg_hit)
      edg_flag_r <= 1'b1;
    else if (!RST_B_IN)
      edg_flag_r <= 1'b0;
    else if (bus.rd && flg_rsel)
      edg_flag_r <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Interval timer
  // ------------------------------------------------------------------
  logic [7:0] tmr_cnt_r;
  logic [9:0] pre_cnt_r;
  rit_div_e   div_r;
  logic       tmr_flag_r;
  logic       tick;
  logic [9:0] pre_max;

  always_comb
  begin
    case (div_r)
      RIT_DIV1:    pre_max = 10'h000;
      RIT_DIV8:    pre_max = PRE_DIV8;
      RIT_DIV64:   pre_max = PRE_DIV64;
      RIT_DIV1024: pre_max = PRE_DIV1024;
      default:     pre_max = 10'h000;
    endcase
  end

  // After the flag the divisor is bypassed.
  assign tick = tmr_flag_r || (pre_cnt_r == pre_max);

  logic tmr_wr;
  logic tmr_acc;
  logic tmr_set;
  assign tmr_wr  = bus.wr && tmr_sel;
  assign tmr_acc = (bus.wr || bus.rd) && tmr_sel;
  assign tmr_set = !tmr_flag_r && tick && (tmr_cnt_r == 8'h00) && !tmr_wr;

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      tmr_cnt_r <= TMR_RST;
      pre_cnt_r <= 10'h000;
      div_r     <= RIT_DIV1;
    end
    else if (tmr_wr)
    begin
      tmr_cnt_r <= bus.wdata;
      div_r     <= rit_div_e'(bus.addr[1:0]);
      pre_cnt_r <= 10'h000;
    end
    else
    begin
      pre_cnt_r <= tick ? 10'h000 : pre_cnt_r + 10'h001;
      if (tick)
        tmr_cnt_r <= tmr_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      tmr_flag_r <= 1'b0;
    else if (tmr_set)
      tmr_flag_r <= 1'b1;
    else if (tmr_acc && tmr_flag_r)
      tmr_flag_r <= 1'b0;
  end

  assign TIMER_FLAG_OUT = tmr_flag_r;
  assign EDGE_FLAG_OUT  = edg_flag_r;

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (ram_sel)
      rdata_nxt = ram_r[bus.addr[RAM_AW-1:0]];
    else if (port_sel)
    begin
      case (bus.addr[1:0])
        PORT_A_DATA: rdata_nxt = PORT_A_IN;
        PORT_A_DIR:  rdata_nxt = a_dir_r;
        PORT_B_DATA: rdata_nxt = PORT_B_IN & PORT_B_MASK;
        PORT_B_DIR:  rdata_nxt = b_dir_r;
        default:     rdata_nxt = 8'h00;
      endcase
    end
    else if (tmr_sel)
      rdata_nxt = tmr_cnt_r;
    else if (flg_rsel)
    begin
      rdata_nxt[FLAG_TMR_BIT] = tmr_flag_r;
      rdata_nxt[FLAG_EDG_BIT] = edg_flag_r;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      RDATA_OUT <= 8'h00;
    else if (bus.rd)
      RDATA_OUT <= rdata_nxt;
  end

endmodule

`default_nettype wire

// *** rit_pin_model.sv ***
/*
  Devices on a port: a line is driven by the block when enabled, else by
  an outside driver, else pulled high. Assumes per-line enables.
*/
`timescale 1ns/100ps
`default_nettype none
module rit_pin_model (
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_in,
  output logic      [7:0] pin_out
);
  // A released line with no outside driver enabled goes to the pull-up level, so no stale value lingers.
  assign pin_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in) | (~oe_in & ~ext_en_in);
endmodule
`default_nettype wire

// *** rit_pkg.sv ***
/*
  Package for the RAM, port and interval timer peripheral section.
  Holds address decode constants, timer prescale codes, flag positions,
  reset values and the bus request carrier struct.
  Assumes a 13-bit processor address bus and an 8-bit data bus.
*/
//
// Summary of operation
// - RAM selected by A7 high, A12 and A9 low.
// - Direction bit 0 input, 1 output.
// - Output lines drive their latch bit.
// - Port reads return pin levels.
// - Latch writes stored while line is input.
// - Port B has five lines: 0,1,3,6,7.
// - Active edge on line sets flag bit 6.
// - Polarity chosen by A0 of special write.
// - Polarity write ignores the data bus.
// - Edge detection works in any line mode.
// - Reset selects falling edge polarity.
// - Reading flag register clears edge flag.
// - Timer counts 255 intervals, selectable divisor.
// - Timer write loads count, A1:A0 picks divisor.
// - Read before flag gives intervals remaining.
// - Flag sets after zero, counter reads ones.
// - After flag, decrement every clock.
// - Timer access after flag clears flag.
// - Read in flag-setting cycle keeps flag.
// - Flag register: bit 7 timer, bit 6 edge.
// - Peripherals decode with A7 high, A12 low.
//
package rit_pkg;

  // ------------------------------------------------------------------
  // Bus widths and carrier
  // ------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rit_bus_s;

  // ------------------------------------------------------------------
  // Address decode bit positions
  // ------------------------------------------------------------------
  localparam int A_SEL_HI  = 7;
  localparam int A_SEL_LO  = 12;
  localparam int A_RAM_SEL = 9;
  localparam int A_TMR_SEL = 4;
  localparam int A_EDG_SEL = 2;
  localparam int RAM_AW    = 7;

  // Low bits A1..A0 for the port registers (A9=1, A4=0, A2=0).
  localparam logic [1:0] PORT_A_DATA = 2'h0;
  localparam logic [1:0] PORT_A_DIR  = 2'h1;
  localparam logic [1:0] PORT_B_DATA = 2'h2;
  localparam logic [1:0] PORT_B_DIR  = 2'h3;

  // ------------------------------------------------------------------
  // Flags, polarity and reset values
  // ------------------------------------------------------------------
  localparam int FLAG_TMR_BIT = 7;
  localparam int FLAG_EDG_BIT = 6;
  localparam logic       POL_FALL      = 1'b0;
  localparam logic [7:0] PORT_B_MASK   = 8'hCB;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic [7:0] LATCH_RST     = 8'h00;
  localparam logic [7:0] TMR_RST       = 8'hFF;

  typedef enum logic [1:0] {
    RIT_DIV1    = 2'b00,
    RIT_DIV8    = 2'b01,
    RIT_DIV64   = 2'b10,
    RIT_DIV1024 = 2'b11
  } rit_div_e;

  localparam logic [9:0] PRE_DIV8    = 10'h007;
  localparam logic [9:0] PRE_DIV64   = 10'h03F;
  localparam logic [9:0] PRE_DIV1024 = 10'h3FF;

endpackage
